/* verilog/bsq_regs.svh */
// Purpose: Register offsets, field positions, reset values and fixed counts of the branch sequencer.
// Assumes: Included by its bare name from the package and the design module.
// Notes:   Offsets are byte addresses on the Avalon-MM slave; each register is one 32-bit word.
`ifndef BSQ_REGS_SVH
`define BSQ_REGS_SVH

`define BSQ_ADDR_W         4
`define BSQ_OFF_STATUS     4'h0
`define BSQ_OFF_EPTR       4'h4
`define BSQ_OFF_PADDR      4'h8
`define BSQ_OFF_STATE      4'hC

`define BSQ_STAT_BOUND_BIT 0
`define BSQ_STAT_FREQ_BIT  1
`define BSQ_STAT_EPTR_LSB  4

`define BSQ_EPTR_RST       4'h0
`define BSQ_PADDR_RST      16'h0000
`define BSQ_EPTR_BOUND     4'hE

`define BSQ_STEP_SHORT     16'h0001
`define BSQ_STEP_LONG      16'h0002

`define BSQ_OPC_MSB        15
`define BSQ_OPC_LSB        9
`define BSQ_UNCOND_TAG     4'h7
`define BSQ_COND_TAG       2'h2

`endif

/* verilog/bsq_pkg.sv */
// Purpose: Types shared by the branch sequencer and its bench.
// Assumes: bsq_regs.svh holds the register and opcode constants; state and criterion encodings are set here.
// Notes:   States are one-hot; structs carry grouped request and answer signals.
`include "bsq_regs.svh"

package bsq_pkg;

  typedef logic [15:0] bsq_word_t;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_COND   = 8'h02,
    ST_RP     = 8'h04,
    ST_BG     = 8'h08,
    ST_ADD    = 8'h10,
    ST_LOADP  = 8'h20,
    ST_FETCH  = 8'h40,
    ST_WAITII = 8'h80
  } bsq_state_e;

  typedef enum logic [1:0] {
    CRIT_CARRY_ZERO = 2'h0,
    CRIT_CARRY_SET  = 2'h1,
    CRIT_ACC_ZERO   = 2'h2,
    CRIT_ACC_NONZ   = 2'h3
  } bsq_crit_e;

  typedef struct packed {
    logic      valid;
    bsq_word_t pAddr;
    bsq_word_t parcel;
  } bsq_issue_s;

  typedef struct packed {
    logic      isBranch;
    logic      cond;
    logic [2:0] mode;
    bsq_crit_e crit;
    logic [8:0] d;
    bsq_word_t pAddr;
  } bsq_op_s;

  typedef struct packed {
    logic      req;
    bsq_word_t addr;
  } bsq_fetch_s;

  typedef struct packed {
    logic      valid;
    logic [3:0] ptr;
    bsq_word_t data;
  } bsq_push_s;

  typedef struct packed {
    logic      valid;
    bsq_word_t addr;
  } bsq_seq_s;

endpackage : bsq_pkg

/* verilog/bsq_branch_sequencer.sv */
// Purpose: Branch sequencer: unconditional modes 070-077 and conditional branches 100-137.
// Assumes: All inputs come from logic on clk_sys; parcel opcode in bits 15:9, designator in 8:0.
// Notes:   Accumulator and carry are only read here; the target sum uses private registers.
`timescale 1ns/10ps
`include "bsq_regs.svh"

// Function
// (RULE1) Indexed return pushes P+2, advances exit pointer.
// (RULE2) Indexed target is operand register plus parcel.
// (RULE3) Target addition is 16-bit two's complement.
// (RULE4) Accumulator and carry untouched; background adder only.
// (RULE5) Boundary flag when advanced pointer equals 14.
// (RULE6) Fetch-request flag when base operand is zero.
// (RULE7) Hold issue until new instruction reaches issue.
// (RULE8) CP1 designator to index; CP2 background loads.
// (RULE9) Addend load waits for missing next parcel.
// (RULE10) CP3 add, advance; CP4 push, P, fetch.
// (RULE11) Fetch waits for acceptance, then instruction arrives.
// (RULE12) Opcodes 100-137 are conditional forms of 070-077.
// (RULE13) Low two bits select criterion; group selects mode.
// (RULE14) Carry criteria test carry clear or set.
// (RULE15) Accumulator criteria test zero or nonzero.
// (RULE16) Taken conditional follows unconditional schedule.
// (RULE17) Criterion valid one cycle after accumulator load.
// (RULE18) Valid criterion, not taken: next issues immediately.
// (RULE19) Relative modes add or subtract unsigned 9-bit designator.
// (RULE20) Other return modes push next sequential address.
// (RULE21) Untaken two-parcel branch skips its constant parcel.
module bsq_branch_sequencer
  import bsq_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire bsq_issue_s                 issueIn,
  input  wire bsq_word_t                  nextParcel,
  input  wire logic                       nextParcelValid,
  input  wire bsq_word_t                  operandData,
  input  wire bsq_word_t                  accData,
  input  wire logic                       carryFlag,
  input  wire logic                       accLoad,
  input  wire logic                       fetchAccept,
  input  wire logic                       iiLoaded,
  input  wire logic [`BSQ_ADDR_W-1:0]     avAddress,
  input  wire logic                       avRead,
  input  wire logic                       avWrite,
  input  wire logic [31:0]                avWritedata,
  input  wire logic [3:0]                 avByteenable,
  output logic [31:0]                     avReaddata_q,
  output logic                            avWaitrequest_q,
  output logic [8:0]                      operandIdx_q,
  output logic                            issueHold_q,
  output bsq_fetch_s                      fetchOut_q,
  output bsq_push_s                       pushOut_q,
  output bsq_seq_s                        seqOut_q,
  output bsq_word_t                       pAddr_q,
  output logic                            boundaryFlag_q,
  output logic                            fetchFlag_q
);

  bsq_state_e state_q;
  bsq_state_e state_d;
  bsq_op_s    op_q;
  bsq_op_s    issueOp;
  bsq_op_s    curOp;
  bsq_word_t  bgAcc_q;
  bsq_word_t  bgAdd_q;
  bsq_word_t  sum;
  logic [3:0] ePtr_q;
  logic [3:0] ePtrInc;
  logic       evalNow;
  logic       takeNow;
  logic       skipNow;
  logic       waitCrit;
  logic       opReg;
  logic       opRet;
  logic       opK;
  logic       curReg;
  logic       curK;
  logic       bgReady;
  logic       busAct;
  logic       busWr;
  logic       busRd;

  // Splits a parcel into mode, criterion and designator.
  function automatic bsq_op_s bsqDecode(input bsq_issue_s iss);
    bsq_op_s    o;
    logic [6:0] opc;
    opc        = iss.parcel[`BSQ_OPC_MSB:`BSQ_OPC_LSB];
    o.d        = iss.parcel[8:0];
    o.pAddr    = iss.pAddr;
    o.isBranch = 1'b0;
    o.cond     = 1'b0;
    o.mode     = opc[2:0];
    o.crit     = CRIT_CARRY_ZERO;
    if (opc[6:3] == `BSQ_UNCOND_TAG) begin
      o.isBranch = 1'b1;
    end else if (opc[6:5] == `BSQ_COND_TAG) begin // RULE12
      o.isBranch = 1'b1;
      o.cond     = 1'b1;
      o.mode     = opc[4:2]; // RULE13
      o.crit     = bsq_crit_e'(opc[1:0]); // RULE13
    end
    return o;
  endfunction : bsqDecode

  // Evaluates one branch criterion against the live carry and accumulator.
  function automatic logic bsqCrit(input bsq_crit_e c, input logic cy, input bsq_word_t acc);
    logic r;
    case (c)
      CRIT_CARRY_ZERO: r = !cy; // RULE14
      CRIT_CARRY_SET:  r = cy; // RULE14
      CRIT_ACC_ZERO:   r = (acc == 16'h0000); // RULE15
      CRIT_ACC_NONZ:   r = (acc != 16'h0000); // RULE15
      default:         r = 1'b0;
    endcase
    return r;
  endfunction : bsqCrit

  // Mode bit 2 marks register-based modes, bit 1 return modes, bits 2 and 0 the k parcel.
  function automatic logic [2:0] bsqModeFlags(input logic [2:0] m);
    return {m[2], m[1], m[2] & m[0]};
  endfunction : bsqModeFlags

  always_comb begin
    issueOp = bsqDecode(issueIn);
    curOp   = (state_q == ST_COND) ? op_q : issueOp;
    {curReg, opRet, curK} = bsqModeFlags(curOp.mode);
    {opReg, opRet, opK}   = bsqModeFlags(op_q.mode);
    waitCrit = (state_q == ST_IDLE) && issueIn.valid && issueOp.isBranch
               && issueOp.cond && accLoad; // RULE17
    evalNow = 1'b0;
    if (state_q == ST_IDLE) begin
      evalNow = issueIn.valid && issueOp.isBranch && !waitCrit;
    end else if (state_q == ST_COND) begin
      evalNow = !accLoad; // RULE17
    end
    takeNow = evalNow && (!curOp.cond || bsqCrit(curOp.crit, carryFlag, accData));
    skipNow = evalNow && !takeNow;
    bgReady = !(opReg && opK) || nextParcelValid; // RULE9
    ePtrInc = ePtr_q + 4'h1;
  end

  // The sum is formed only from the background registers, never the live accumulator.
  always_comb begin
    if (!op_q.mode[2] && op_q.mode[0]) begin
      sum = bgAcc_q - bgAdd_q; // RULE19 RULE3
    end else begin
      sum = bgAcc_q + bgAdd_q; // RULE3 RULE4
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (waitCrit) begin
          state_d = ST_COND;
        end else if (takeNow) begin
          state_d = curReg ? ST_RP : ST_BG; // RULE16
        end
      end
      ST_COND: begin
        if (takeNow) begin
          state_d = curReg ? ST_RP : ST_BG; // RULE16
        end else if (skipNow) begin
          state_d = ST_IDLE;
        end
      end
      ST_RP:     state_d = ST_BG; // RULE8
      ST_BG:     state_d = bgReady ? ST_ADD : ST_BG; // RULE9
      ST_ADD:    state_d = opReg ? ST_FETCH : ST_LOADP; // RULE10
      ST_LOADP:  state_d = ST_FETCH;
      ST_FETCH:  state_d = fetchAccept ? ST_WAITII : ST_FETCH; // RULE11
      ST_WAITII: state_d = iiLoaded ? ST_IDLE : ST_WAITII; // RULE11
      default:   state_d = ST_IDLE;
    endcase
  end

  // Hold follows the next state so that an untaken branch stalls issue only for the ST_COND cycle while its criterion forms.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      issueHold_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      issueHold_q <= (state_d != ST_IDLE); // RULE7 RULE17 RULE18
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_q <= '0;
    end else if (state_q == ST_IDLE && issueIn.valid) begin
      op_q <= issueOp;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      operandIdx_q <= 9'h000;
    end else if (takeNow && curReg) begin
      operandIdx_q <= curOp.d; // RULE8
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bgAcc_q <= 16'h0000;
      bgAdd_q <= 16'h0000;
    end else if (state_q == ST_BG && bgReady) begin
      if (opReg) begin
        bgAcc_q <= operandData; // RULE8
        bgAdd_q <= opK ? nextParcel : 16'h0000; // RULE2 RULE9
      end else begin
        bgAcc_q <= op_q.pAddr;
        bgAdd_q <= {7'h00, op_q.d}; // RULE19
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pAddr_q    <= `BSQ_PADDR_RST;
      fetchOut_q <= '0;
    end else begin
      if (state_q == ST_ADD) begin
        pAddr_q <= sum; // RULE2 RULE10
      end
      if (state_q == ST_ADD && opReg) begin
        fetchOut_q.req  <= 1'b1; // RULE10
        fetchOut_q.addr <= sum;
      end else if (state_q == ST_LOADP) begin
        fetchOut_q.req  <= 1'b1;
        fetchOut_q.addr <= pAddr_q;
      end else if (state_q == ST_FETCH && fetchAccept) begin
        fetchOut_q.req  <= 1'b0; // RULE11
      end
    end
  end

  // A bus write to the pointer loses against a hardware advance in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ePtr_q    <= `BSQ_EPTR_RST;
      pushOut_q <= '0;
    end else begin
      pushOut_q.valid <= 1'b0;
      if (state_q == ST_ADD && opRet) begin
        ePtr_q          <= ePtrInc; // RULE1 RULE10
        pushOut_q.valid <= 1'b1;
        pushOut_q.ptr   <= ePtrInc;
        pushOut_q.data  <= op_q.pAddr + (opK ? `BSQ_STEP_LONG : `BSQ_STEP_SHORT); // RULE1 RULE20
      end else if (busWr && avAddress == `BSQ_OFF_EPTR && avByteenable[0]) begin
        ePtr_q <= avWritedata[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seqOut_q <= '0;
    end else begin
      seqOut_q.valid <= skipNow; // RULE18
      if (skipNow) begin
        seqOut_q.addr <= curOp.pAddr + (curK ? `BSQ_STEP_LONG : `BSQ_STEP_SHORT); // RULE21
      end
    end
  end

  // Flags are write-one-to-clear; a set in the same cycle wins.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boundaryFlag_q <= 1'b0;
      fetchFlag_q    <= 1'b0;
    end else begin
      if (state_q == ST_ADD && opRet && ePtrInc == `BSQ_EPTR_BOUND) begin
        boundaryFlag_q <= 1'b1; // RULE5
      end else if (busWr && avAddress == `BSQ_OFF_STATUS && avByteenable[0]
                   && avWritedata[`BSQ_STAT_BOUND_BIT]) begin
        boundaryFlag_q <= 1'b0;
      end
      if (state_q == ST_BG && bgReady && opReg && operandData == 16'h0000) begin
        fetchFlag_q <= 1'b1; // RULE6
      end else if (busWr && avAddress == `BSQ_OFF_STATUS && avByteenable[0]
                   && avWritedata[`BSQ_STAT_FREQ_BIT]) begin
        fetchFlag_q <= 1'b0;
      end
    end
  end

  // Every access takes exactly one wait cycle; reads are captured on the first cycle.
  always_comb begin
    busAct = (avRead || avWrite) && !avWaitrequest_q;
    busWr  = busAct && avWrite;
    busRd  = (avRead && avWaitrequest_q);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avWaitrequest_q <= 1'b1;
      avReaddata_q    <= 32'h00000000;
    end else begin
      avWaitrequest_q <= !((avRead || avWrite) && avWaitrequest_q);
      if (busRd) begin
        case (avAddress)
          `BSQ_OFF_STATUS: avReaddata_q <= {24'h000000, ePtr_q, 2'h0, fetchFlag_q,
                                            boundaryFlag_q};
          `BSQ_OFF_EPTR:   avReaddata_q <= {28'h0000000, ePtr_q};
          `BSQ_OFF_PADDR:  avReaddata_q <= {16'h0000, pAddr_q};
          `BSQ_OFF_STATE:  avReaddata_q <= {24'h000000, state_q};
          default:         avReaddata_q <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : bsq_branch_sequencer

/* tb/bsq_seq_properties.sv */
// Purpose: Port-level checks of the branch sequencer.
// Assumes: One clock; rst is synchronous and active high.
// Notes:   The opcode is parcel[15:9]; conditional codes have opc[6:5] == 2'b10.
`timescale 1ns/10ps
module bsq_seq_chk
  import bsq_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire bsq_issue_s issueIn,
  input wire logic       nextParcelValid,
  input wire bsq_word_t  accData,
  input wire logic       carryFlag,
  input wire logic       accLoad,
  input wire logic       fetchAccept,
  input wire logic [8:0] operandIdx_q,
  input wire logic       issueHold_q,
  input wire bsq_fetch_s fetchOut_q,
  input wire bsq_push_s  pushOut_q,
  input wire bsq_seq_s   seqOut_q,
  input wire bsq_word_t  pAddr_q,
  input wire logic       boundaryFlag_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic [6:0] opc = issueIn.parcel[15:9];
  wire logic       go  = issueIn.valid && !issueHold_q;
  wire logic       cnd = go && opc[6:5] == 2'b10 && !accLoad;
  // The parcel must stay present through the background load, else the push slips.
  sequence sIdxRet;
    go && opc == 7'h3F ##1 nextParcelValid [*2];
  endsequence
  sequence sPush;
    pushOut_q.valid && pushOut_q.data == $past(issueIn.pAddr, 4) + 16'h0002;
  endsequence
  a_idx_push: assert property (sIdxRet |-> ##2 sPush)
    else $error("indexed return push wrong");
  a_idx_start: assert property (go && opc[6:2] == 5'h0F |=> issueHold_q &&
    operandIdx_q == $past(issueIn.parcel[8:0]))
    else $error("operand index not loaded");
  a_fetch_addr: assert property (fetchOut_q.req |->
    fetchOut_q.addr == pAddr_q && issueHold_q)
    else $error("fetch address or hold wrong");
  a_req_held: assert property (fetchOut_q.req && !fetchAccept |=>
    fetchOut_q.req && $stable(fetchOut_q.addr))
    else $error("fetch request dropped early");
  a_bound_set: assert property (pushOut_q.valid && pushOut_q.ptr == 4'hE |->
    ##[0:1] boundaryFlag_q)
    else $error("boundary flag not set");
  a_acc_wait: assert property (go && opc[6:5] == 2'b10 && accLoad |=> issueHold_q)
    else $error("no hold while criterion forms");
  a_carry_skip: assert property (cnd && opc[1:0] == 2'h0 && carryFlag |=>
    seqOut_q.valid && !issueHold_q)
    else $error("carry branch not skipped");
  a_nonz_skip: assert property (cnd && opc[1:0] == 2'h3 && accData == 16'h0000 |=>
    seqOut_q.valid && !fetchOut_q.req)
    else $error("nonzero branch not skipped");
endmodule : bsq_seq_chk

bind bsq_branch_sequencer bsq_seq_chk uChk (
  .clk_sys(clk_sys), .rst(rst), .issueIn(issueIn), .nextParcelValid(nextParcelValid),
  .accData(accData), .carryFlag(carryFlag), .accLoad(accLoad), .fetchAccept(fetchAccept),
  .operandIdx_q(operandIdx_q), .issueHold_q(issueHold_q), .fetchOut_q(fetchOut_q),
  .pushOut_q(pushOut_q), .seqOut_q(seqOut_q), .pAddr_q(pAddr_q),
  .boundaryFlag_q(boundaryFlag_q)
);

/* tb/bsq_mem_model.sv */
// Purpose: Local memory fetch port facing the sequencer.
// Assumes: A fetch request is a level held until accepted.
// Notes:   lat adds conflict cycles before acceptance.
`timescale 1ns/10ps
module bsq_mem_model
  import bsq_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire bsq_fetch_s fetchOut_q,
  input  wire logic [3:0] lat,
  output logic            fetchAccept,
  output logic            iiLoaded
);
  logic [3:0] waitCnt_q;
  // Acceptance is one pulse; the word reaches the issue register a cycle later.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waitCnt_q <= 4'h0;
      fetchAccept <= 1'b0;
      iiLoaded <= 1'b0;
    end else begin
      iiLoaded <= fetchAccept;
      fetchAccept <= 1'b0;
      if (fetchOut_q.req && !fetchAccept) begin
        waitCnt_q <= waitCnt_q + 4'h1;
        if (waitCnt_q == lat) begin
          fetchAccept <= 1'b1;
          waitCnt_q <= 4'h0;
        end
      end
    end
  end
endmodule : bsq_mem_model

/* tb/tb_branch_sequencer.sv */
// Purpose: Self-checking bench for the branch sequencer.
// Assumes: Operand register 0 holds zero and every other one holds OPV.
// Notes:   A monitor catches fetch, push and continue events.
`timescale 1ns/10ps
module tb_branch_sequencer;
  import bsq_pkg::*;
  localparam bsq_word_t OPV = 16'hF000;
  localparam bsq_word_t KV  = 16'h1234;
  localparam bsq_word_t TGT = OPV + KV;
  logic        clk_sys = 1'b0, rst = 1'b1, accLoad = 1'b0, carryFlag = 1'b0;
  logic        nextParcelValid = 1'b1, avRead = 1'b0, avWrite = 1'b0;
  bsq_issue_s  issueIn = '0;
  bsq_word_t   accData = '0, nextParcel = KV, pAddr_q;
  logic [3:0]  avAddress = '0, avByteenable = 4'hF, memLat = 4'h0;
  logic [31:0] avWritedata = '0, avReaddata_q, rdv, lastFetch, lastSeq, lastPush;
  logic [8:0]  operandIdx_q;
  logic        avWaitrequest_q, issueHold_q, boundaryFlag_q, fetchFlag_q, fetchAccept, iiLoaded;
  bsq_fetch_s  fetchOut_q;
  bsq_push_s   pushOut_q;
  bsq_seq_s    seqOut_q;
  int          errTotal = 0, cmpCount = 0;
  wire bsq_word_t operandData = (operandIdx_q == 9'h000) ? 16'h0000 : OPV;
  bsq_branch_sequencer DUT (
    .clk_sys(clk_sys), .rst(rst), .issueIn(issueIn), .nextParcel(nextParcel),
    .nextParcelValid(nextParcelValid), .operandData(operandData), .accData(accData),
    .carryFlag(carryFlag), .accLoad(accLoad), .fetchAccept(fetchAccept), .iiLoaded(iiLoaded),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata),
    .avByteenable(avByteenable), .avReaddata_q(avReaddata_q),
    .avWaitrequest_q(avWaitrequest_q), .operandIdx_q(operandIdx_q), .issueHold_q(issueHold_q),
    .fetchOut_q(fetchOut_q), .pushOut_q(pushOut_q), .seqOut_q(seqOut_q), .pAddr_q(pAddr_q),
    .boundaryFlag_q(boundaryFlag_q), .fetchFlag_q(fetchFlag_q)
  );
  bsq_mem_model uMem (.clk_sys(clk_sys), .rst(rst), .fetchOut_q(fetchOut_q), .lat(memLat),
    .fetchAccept(fetchAccept), .iiLoaded(iiLoaded));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (fetchOut_q.req && fetchAccept) lastFetch = {16'h0, fetchOut_q.addr};
    if (pushOut_q.valid) lastPush = {12'h0, pushOut_q.ptr, pushOut_q.data};
    if (seqOut_q.valid) lastSeq = {16'h0, seqOut_q.addr};
  end
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    avAddress <= a;
    avWritedata <= wd;
    avRead <= !wr;
    avWrite <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avWaitrequest_q !== 1'b0 && n < 50);
    // A bus access that never sees waitrequest low is a failure, not a silent pass.
    if (avWaitrequest_q !== 1'b0) begin
      errTotal++;
      $display("unexpected waitrequest: expected 0, seen %b", avWaitrequest_q);
    end
    rdv = avReaddata_q;
    avRead <= 1'b0;
    avWrite <= 1'b0;
  endtask : av
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    av(1'b0, a, '0);
    chk(nm, e, rdv);
  endtask : rd
  // The parcel can be held back kd cycles to stall the background load.
  task automatic br(input logic [6:0] op, input logic [8:0] d, input bsq_word_t p,
                    input int kd, input logic al);
    int n;
    @(posedge clk_sys);
    lastFetch = 'x;
    lastSeq = 'x;
    lastPush = 'x;
    issueIn <= '{valid: 1'b1, pAddr: p, parcel: {op, d}};
    nextParcelValid <= (kd == 0);
    accLoad <= al;
    @(posedge clk_sys);
    issueIn.valid <= 1'b0;
    accLoad <= 1'b0;
    repeat (kd) @(posedge clk_sys);
    nextParcelValid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((issueHold_q !== 1'b0 || n < 3) && n < 300);
    // A hold that never drops means the branch hung.
    if (issueHold_q !== 1'b0) begin
      errTotal++;
      $display("unexpected issueHold: expected 0, seen %b", issueHold_q);
    end
  endtask : br
  initial begin
    repeat (20000) @(posedge clk_sys);
    errTotal++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 32'h0, "status");
    rd(4'h4, 32'h0, "eptr");
    rd(4'hC, {24'h0, ST_IDLE}, "state");
    rd(4'h2, 32'h0, "unmapped");
    av(1'b1, 4'h4, 32'hD);
    memLat <= 4'h3;
    br(7'h3F, 9'h001, 16'h0100, 4, 1'b0);
    chk("fetch", {16'h0, TGT}, lastFetch);
    chk("push", {12'h0, 4'hE, 16'h0102}, lastPush);
    rd(4'h0, 32'hE1, "status");
    rd(4'h8, {16'h0, TGT}, "paddr");
    memLat <= 4'h0;
    br(7'h3C, 9'h000, 16'h0100, 0, 1'b0);
    chk("fetch", 32'h0, lastFetch);
    rd(4'h0, 32'hE3, "status");
    av(1'b1, 4'h0, 32'h3);
    rd(4'h0, 32'hE0, "status");
    br(7'h3F, 9'h001, 16'h0300, 0, 1'b0);
    chk("push", {12'h0, 4'hF, 16'h0302}, lastPush);
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 4; c++) begin
        carryFlag <= (c == 0) ^ t[0];
        accData <= {15'h0, (c == 2) ^ t[0]};
        br(7'h40 + 7'(c), 9'h008, 16'h0200, 0, 1'b0);
        if (t == 1) chk("fetch", 32'h0208, lastFetch);
        else chk("continue", 32'h0201, lastSeq);
      end
    end
    carryFlag <= 1'b1;
    br(7'h45, 9'h008, 16'h0200, 0, 1'b0);
    chk("fetch", 32'h01F8, lastFetch);
    br(7'h49, 9'h008, 16'h0200, 0, 1'b0);
    chk("push", 32'h0201, {16'h0, lastPush[15:0]});
    accData <= 16'h0000;
    br(7'h57, 9'h001, 16'h0200, 0, 1'b0);
    chk("continue", 32'h0202, lastSeq);
    br(7'h40, 9'h008, 16'h0200, 0, 1'b1);
    chk("continue", 32'h0201, lastSeq);
    end_of_test();
  end
endmodule : tb_branch_sequencer
